// File: include/pfo_pkg.sv
// Constants, register map and types for the pulse-width and square-wave output block
package pfo_pkg;
    localparam longint CLK_HZ = 250_000_000;
    localparam longint TICK_HZ = 1_000_000;
    localparam int TICK_DIV = int'(CLK_HZ / TICK_HZ);
    localparam int DIV_W = 8;
    localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(TICK_DIV - 1);
    localparam longint SQ_MAX_HZ = 4_000_000;
    localparam int PHASE_W = 32;
    localparam logic [PHASE_W-1:0] SQ_MAX_INC = PHASE_W'((SQ_MAX_HZ << PHASE_W) / CLK_HZ);

    localparam int NPIN = 16;
    localparam int CNT_W = 16;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;

    localparam logic [ADDR_W-1:0] CTRL_ADDR = 8'h00;
    localparam logic [ADDR_W-1:0] MODE_ADDR = 8'h04;
    localparam logic [ADDR_W-1:0] LEVEL_ADDR = 8'h08;
    localparam logic [ADDR_W-1:0] PERIOD_ADDR = 8'h0C;
    localparam logic [ADDR_W-1:0] SQINC_ADDR = 8'h10;
    localparam logic [ADDR_W-1:0] PINS_ADDR = 8'h14;
    localparam logic [ADDR_W-1:0] COUNT_ADDR = 8'h18;
    localparam logic [1:0] DUTY_PAGE = 2'h1;

    localparam int CTRL_RUN_BIT = 0;
    localparam int CTRL_SYNC_BIT = 1;
    localparam int MODE_W = 2;

    localparam logic [1:0] CTRL_RST = 2'h0;
    localparam logic [CNT_W-1:0] PERIOD_MIN = 16'h0001;
    localparam logic [CNT_W-1:0] PERIOD_RST = 16'h03E8;
    localparam logic [CNT_W-1:0] DUTY_RST = 16'h8000;
    localparam logic [PHASE_W-1:0] SQINC_RST = 32'h0000_0000;

    typedef enum logic [MODE_W-1:0] {
        PFO_OFF,
        PFO_LEVEL,
        PFO_PWM,
        PFO_SQUARE
    } pfo_mode_t;
endpackage

// File: include/pfo_time_if.sv
// Interface joining the register block to the shared timebase
`timescale 1ns/1ns
interface pfo_time_if;
    logic run;
    logic sync;
    logic [pfo_pkg::CNT_W-1:0] periodTicks;
    logic [pfo_pkg::PHASE_W-1:0] sqInc;
    logic [pfo_pkg::CNT_W-1:0] count;
    logic wrap;
    logic [pfo_pkg::PHASE_W-1:0] phase;

    modport gen (
        input run,
        input sync,
        input periodTicks,
        input sqInc,
        output count,
        output wrap,
        output phase
    );
    modport use_side (
        output run,
        output sync,
        output periodTicks,
        output sqInc,
        input count,
        input wrap,
        input phase
    );
endinterface

// File: src/pfo_timebase.sv
// Shared 1 MHz period counter and square-wave phase accumulator
`timescale 1ns/1ns
module pfo_timebase (
    input wire logic clk,
    input wire logic rst,
    pfo_time_if.gen tb
);
    logic [pfo_pkg::DIV_W-1:0] div_reg, div_next;
    logic [pfo_pkg::CNT_W-1:0] count_reg, count_next;
    logic wrap_reg, wrap_next;
    logic [pfo_pkg::PHASE_W-1:0] phase_reg, phase_next;
    logic tick;
    logic lastStep;

    always_comb begin
        tick = (div_reg == pfo_pkg::DIV_LAST);
        lastStep = (count_reg >= tb.periodTicks - pfo_pkg::PERIOD_MIN);
        div_next = tick ? '0 : div_reg + 1'b1;
        count_next = count_reg;
        wrap_next = 1'b0;
        if (tick) begin
            // Period of N ticks gives 1 MHz / N, so N = 1 is the fastest
            count_next = lastStep ? '0 : count_reg + 1'b1;
            wrap_next = lastStep;
        end
        // Phase MSB completes one high-low cycle at inc * clk / 2^32; inc of zero parks it
        phase_next = phase_reg + tb.sqInc;
        if (!tb.run || tb.sync) begin
            div_next = '0;
            count_next = '0;
            wrap_next = 1'b0;
            phase_next = '0;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            div_reg <= '0;
            count_reg <= '0;
            wrap_reg <= 1'b0;
            phase_reg <= '0;
        end else begin
            div_reg <= div_next;
            count_reg <= count_next;
            wrap_reg <= wrap_next;
            phase_reg <= phase_next;
        end
    end

    assign tb.count = count_reg;
    assign tb.wrap = wrap_reg;
    assign tb.phase = phase_reg;
endmodule

// File: src/pfo_top.sv
// Pulse-width and square-wave pin generator with an Avalon-MM register slave
//
// The address map and the Avalon-MM interface to the registers are this design's own decisions.
`timescale 1ns/1ns
module pfo_top (
    input wire logic clk,
    input wire logic rst,
    input wire logic [pfo_pkg::ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [pfo_pkg::DATA_W-1:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [pfo_pkg::DATA_W-1:0] avs_readdata,
    output logic avs_waitrequest,
    output logic [pfo_pkg::NPIN-1:0] pinOut,
    output logic [pfo_pkg::NPIN-1:0] pinOe
);
    localparam int NP = pfo_pkg::NPIN;
    localparam int CW = pfo_pkg::CNT_W;
    localparam int PW = pfo_pkg::PHASE_W;
    localparam int MW = pfo_pkg::MODE_W;

    pfo_time_if tb ();

    pfo_timebase u_timebase (
        .clk(clk),
        .rst(rst),
        .tb(tb.gen)
    );

    // Software copies of the settings
    logic [1:0] ctrl_reg;
    logic [1:0] ctrl_next;
    logic [NP*MW-1:0] mode_reg;
    logic [NP*MW-1:0] mode_next;
    logic [NP-1:0] level_reg;
    logic [NP-1:0] level_next;
    logic [CW-1:0] period_reg;
    logic [CW-1:0] period_next;
    logic [PW-1:0] sqInc_reg;
    logic [PW-1:0] sqInc_next;
    logic [CW-1:0] duty_reg [NP];
    logic [CW-1:0] duty_next [NP];

    // Active copies, taken at a period boundary, on a restart or while stopped, so a running period or duty change never cuts a PWM pulse short
    logic [CW-1:0] periodAct_reg;
    logic [CW-1:0] periodAct_next;
    logic [CW-1:0] dutyAct_reg [NP];
    logic [CW-1:0] dutyAct_next [NP];

    // Bus handshake state
    logic wait_reg;
    logic wait_next;
    logic [pfo_pkg::DATA_W-1:0] rdata_reg;
    logic [pfo_pkg::DATA_W-1:0] rdata_next;

    // Pin stage
    logic [NP-1:0] pin_reg;
    logic [NP-1:0] pin_next;
    logic [NP-1:0] oe_reg;
    logic [NP-1:0] oe_next;

    logic request;
    logic commit;
    logic wrEn;
    logic dutyHit;
    logic [3:0] dutyIdx;
    logic [pfo_pkg::DATA_W-1:0] readMux;

    function automatic logic [pfo_pkg::DATA_W-1:0] merge_bytes(
        input logic [pfo_pkg::DATA_W-1:0] old,
        input logic [pfo_pkg::DATA_W-1:0] data,
        input logic [3:0] be
    );
        logic [pfo_pkg::DATA_W-1:0] res;
        res = old;
        for (int b = 0; b < 4; b++) begin
            if (be[b]) begin
                res[b*8 +: 8] = data[b*8 +: 8];
            end
        end
        return res;
    endfunction

    assign tb.run = ctrl_reg[pfo_pkg::CTRL_RUN_BIT];
    assign tb.sync = ctrl_reg[pfo_pkg::CTRL_SYNC_BIT];
    assign tb.periodTicks = periodAct_reg;
    assign tb.sqInc = sqInc_reg;

    // Each access holds waitrequest for one cycle, then completes on the next edge
    always_comb begin
        request = avs_read || avs_write;
        commit = request && !wait_reg;
        wrEn = commit && avs_write;
        dutyHit = (avs_address[7:6] == pfo_pkg::DUTY_PAGE);
        dutyIdx = avs_address[5:2];
        wait_next = 1'b1;
        if (request && wait_reg) begin
            wait_next = 1'b0;
        end
    end

    always_comb begin
        readMux = '0;
        if (dutyHit) begin
            readMux = {{(pfo_pkg::DATA_W-CW){1'b0}}, duty_reg[dutyIdx]};
        end else begin
            unique case (avs_address)
                pfo_pkg::CTRL_ADDR: begin
                    readMux = {30'h0000_0000, ctrl_reg};
                end
                pfo_pkg::MODE_ADDR: begin
                    readMux = mode_reg;
                end
                pfo_pkg::LEVEL_ADDR: begin
                    readMux = {16'h0000, level_reg};
                end
                pfo_pkg::PERIOD_ADDR: begin
                    readMux = {16'h0000, period_reg};
                end
                pfo_pkg::SQINC_ADDR: begin
                    readMux = sqInc_reg;
                end
                pfo_pkg::PINS_ADDR: begin
                    readMux = {oe_reg, pin_reg};
                end
                pfo_pkg::COUNT_ADDR: begin
                    readMux = {16'h0000, tb.count};
                end
                default: begin
                    readMux = '0;
                end
            endcase
        end
        // Loaded on the taking edge so the word already stands when waitrequest is seen low
        rdata_next = rdata_reg;
        if (request && wait_reg && avs_read) begin
            rdata_next = readMux;
        end
    end

    // Register writes
    always_comb begin
        logic [pfo_pkg::DATA_W-1:0] merged;
        merged = '0;
        ctrl_next = ctrl_reg;
        mode_next = mode_reg;
        level_next = level_reg;
        period_next = period_reg;
        sqInc_next = sqInc_reg;
        for (int i = 0; i < NP; i++) begin
            duty_next[i] = duty_reg[i];
        end
        // Restart request lasts one cycle
        ctrl_next[pfo_pkg::CTRL_SYNC_BIT] = 1'b0;
        if (wrEn) begin
            if (dutyHit) begin
                merged = merge_bytes({16'h0000, duty_reg[dutyIdx]}, avs_writedata, avs_byteenable);
                duty_next[dutyIdx] = merged[CW-1:0];
            end else begin
                unique case (avs_address)
                    pfo_pkg::CTRL_ADDR: begin
                        merged = merge_bytes({30'h0000_0000, ctrl_reg}, avs_writedata, avs_byteenable);
                        ctrl_next = merged[1:0];
                    end
                    pfo_pkg::MODE_ADDR: begin
                        mode_next = merge_bytes(mode_reg, avs_writedata, avs_byteenable);
                    end
                    pfo_pkg::LEVEL_ADDR: begin
                        merged = merge_bytes({16'h0000, level_reg}, avs_writedata, avs_byteenable);
                        level_next = merged[NP-1:0];
                    end
                    pfo_pkg::PERIOD_ADDR: begin
                        merged = merge_bytes({16'h0000, period_reg}, avs_writedata, avs_byteenable);
                        // Zero would stretch the period to 65536 ticks; one tick is already 1 MHz
                        if (merged[CW-1:0] < pfo_pkg::PERIOD_MIN) begin
                            period_next = pfo_pkg::PERIOD_MIN;
                        end else begin
                            period_next = merged[CW-1:0];
                        end
                    end
                    pfo_pkg::SQINC_ADDR: begin
                        merged = merge_bytes(sqInc_reg, avs_writedata, avs_byteenable);
                        if (merged > pfo_pkg::SQ_MAX_INC) begin
                            sqInc_next = pfo_pkg::SQ_MAX_INC;
                        end else begin
                            sqInc_next = merged;
                        end
                    end
                    default: merged = '0;
                endcase
            end
        end
    end

    // Active settings follow the software copies at a period end or while stopped
    always_comb begin
        periodAct_next = periodAct_reg;
        for (int i = 0; i < NP; i++) begin
            dutyAct_next[i] = dutyAct_reg[i];
        end
        if (tb.wrap || !tb.run || tb.sync) begin
            periodAct_next = period_reg;
            for (int i = 0; i < NP; i++) begin
                dutyAct_next[i] = duty_reg[i];
            end
        end
    end

    // Per-pin routing and compare
    genvar g;
    generate
        for (g = 0; g < NP; g++) begin : gPin
            pfo_pkg::pfo_mode_t mode;
            logic pwmLevel;
            logic sqLevel;
            assign mode = pfo_pkg::pfo_mode_t'(mode_reg[g*MW +: MW]);
            // Count runs 0..N-1: duty 0 never high, duty >= N always high
            assign pwmLevel = tb.run && (tb.count < dutyAct_reg[g]);
            // Shared phase, own threshold; the reset threshold is half a turn
            assign sqLevel = tb.run && (tb.phase[PW-1 -: CW] < dutyAct_reg[g]);
            always_comb begin
                unique case (mode)
                    pfo_pkg::PFO_OFF: begin
                        pin_next[g] = 1'b0;
                        oe_next[g] = 1'b0;
                    end
                    pfo_pkg::PFO_LEVEL: begin
                        pin_next[g] = level_reg[g];
                        oe_next[g] = 1'b1;
                    end
                    pfo_pkg::PFO_PWM: begin
                        pin_next[g] = pwmLevel;
                        oe_next[g] = 1'b1;
                    end
                    pfo_pkg::PFO_SQUARE: begin
                        pin_next[g] = sqLevel;
                        oe_next[g] = 1'b1;
                    end
                endcase
            end
        end
    endgenerate

    // Software settings
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ctrl_reg <= pfo_pkg::CTRL_RST;
            mode_reg <= '0;
            level_reg <= '0;
            period_reg <= pfo_pkg::PERIOD_RST;
            sqInc_reg <= pfo_pkg::SQINC_RST;
            for (int i = 0; i < NP; i++) begin
                duty_reg[i] <= pfo_pkg::DUTY_RST;
            end
        end else begin
            ctrl_reg <= ctrl_next;
            mode_reg <= mode_next;
            level_reg <= level_next;
            period_reg <= period_next;
            sqInc_reg <= sqInc_next;
            for (int i = 0; i < NP; i++) begin
                duty_reg[i] <= duty_next[i];
            end
        end
    end

    // Active copies
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            periodAct_reg <= pfo_pkg::PERIOD_RST;
            for (int i = 0; i < NP; i++) begin
                dutyAct_reg[i] <= pfo_pkg::DUTY_RST;
            end
        end else begin
            periodAct_reg <= periodAct_next;
            for (int i = 0; i < NP; i++) begin
                dutyAct_reg[i] <= dutyAct_next[i];
            end
        end
    end

    // Bus handshake; waitrequest stands high in reset so nothing is taken early
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wait_reg <= 1'b1;
            rdata_reg <= '0;
        end else begin
            wait_reg <= wait_next;
            rdata_reg <= rdata_next;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pin_reg <= '0;
            oe_reg <= '0;
        end else begin
            pin_reg <= pin_next;
            oe_reg <= oe_next;
        end
    end

    assign avs_readdata = rdata_reg;
    assign avs_waitrequest = wait_reg;
    assign pinOut = pin_reg;
    assign pinOe = oe_reg;
endmodule

// File: test/pfo_top_checker.sv
// Bus handshake and pin assertions for the pulse-width and square-wave block
`timescale 1ns/1ns
module pfo_top_checker (
    input wire logic clk,
    input wire logic rst,
    input wire logic [pfo_pkg::ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [pfo_pkg::DATA_W-1:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    input wire logic [pfo_pkg::DATA_W-1:0] avs_readdata,
    input wire logic avs_waitrequest,
    input wire logic [pfo_pkg::NPIN-1:0] pinOut,
    input wire logic [pfo_pkg::NPIN-1:0] pinOe
);
    logic [2:0] sinceWr_reg;
    logic [2:0] sinceWr_next;
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    // Saturating age of the last completed write; enables may only move shortly after one
    always_comb begin
        sinceWr_next = (sinceWr_reg == 3'h7) ? 3'h7 : sinceWr_reg + 3'h1;
        if (avs_write && !avs_waitrequest) begin
            sinceWr_next = 3'h0;
        end
    end
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sinceWr_reg <= 3'h7;
        end else begin
            sinceWr_reg <= sinceWr_next;
        end
    end
    sequence s_taken;
        (avs_read || avs_write) && avs_waitrequest;
    endsequence
    sequence s_read_taken;
        avs_read && avs_waitrequest;
    endsequence
    a_wait_one_state: assert property (s_taken |=> !avs_waitrequest)
        else $error("waitrequest did not drop after a request");
    a_wait_single_cycle: assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("waitrequest low for more than one cycle");
    a_wait_idle_high: assert property (!(avs_read || avs_write) |=> avs_waitrequest)
        else $error("waitrequest low without a request");
    a_reset_wait_high: assert property ($fell(rst) |-> avs_waitrequest)
        else $error("waitrequest low right after reset");
    a_read_data_hold: assert property (!(avs_read && avs_waitrequest) |=> $stable(avs_readdata))
        else $error("read data changed without a read");
    a_unmapped_read_zero: assert property (s_read_taken ##0 (avs_address == 8'h20) |=> avs_readdata == 32'h0)
        else $error("unmapped read not zero");
    a_pins_read_back: assert property (s_read_taken ##0 (avs_address == pfo_pkg::PINS_ADDR)
        |=> avs_readdata == $past({pinOe, pinOut}))
        else $error("pin status read differs from pins");
    a_oe_after_write: assert property ($changed(pinOe) |-> sinceWr_reg <= 3'h4)
        else $error("pin enables changed without a write");
endmodule
bind pfo_top pfo_top_checker u_chk (.clk(clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .pinOut(pinOut), .pinOe(pinOe));

// File: test/pfo_top_tb.sv
// Self-checking bench for the pulse-width and square-wave block
`timescale 1ns/1ns
module pfo_top_tb;
    logic clk;
    logic rst;
    logic [7:0] avs_address;
    logic avs_read;
    logic avs_write;
    logic [31:0] avs_writedata;
    logic [3:0] avs_byteenable;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic [15:0] pinOut;
    logic [15:0] pinOe;
    int n_errors;
    int checks;
    int hi0;
    int hi1;
    int ed0;
    logic [31:0] q;
    logic [7:0] ra [6] = '{8'h00, 8'h04, 8'h0C, 8'h10, 8'h40, 8'h20};
    logic [31:0] rv [6] = '{32'h0, 32'h0, 32'h3E8, 32'h0, 32'h8000, 32'h0};
    int pp [6] = '{4, 4, 4, 2, 10, 4};
    int pd [6] = '{2, 0, 4, 1, 1, 9};
    pfo_top u_dut (.clk(clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .pinOut(pinOut), .pinOe(pinOe));
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    task summarize;
        $display("errors %0d checks %0d", n_errors, checks);
        if (n_errors == 0 && checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // Request held until waitrequest is sampled low; an idle edge follows so strobes never re-rise in one step
    task xfer(input logic rd, input logic [7:0] a, input logic [31:0] d, input logic [3:0] be);
        int i;
        avs_address <= a;
        avs_writedata <= d;
        avs_byteenable <= be;
        avs_read <= rd;
        avs_write <= !rd;
        i = 0;
        do begin
            @(posedge clk);
            i++;
        end while (avs_waitrequest !== 1'b0 && i < 20);
        q = avs_readdata;
        if (avs_waitrequest !== 1'b0) begin
            n_errors++;
            summarize();
        end
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        @(posedge clk);
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d);
        xfer(1'b0, a, d, 4'hF);
    endtask
    task rd(input logic [7:0] a);
        xfer(1'b1, a, 32'h0, 4'hF);
    endtask
    task measure(input int n);
        logic p;
        hi0 = 0;
        hi1 = 0;
        ed0 = 0;
        repeat (8) @(posedge clk);
        p = pinOut[0];
        repeat (n) begin
            @(posedge clk);
            hi0 += int'(pinOut[0]);
            hi1 += int'(pinOut[1]);
            ed0 += int'(pinOut[0] && !p);
            p = pinOut[0];
        end
    endtask
    function automatic logic [31:0] near(int v, int e, int t);
        return 32'((v >= e - t) && (v <= e + t));
    endfunction
    initial begin
        n_errors = 0;
        checks = 0;
        rst = 1'b1;
        avs_address = 8'h0;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h0;
        avs_byteenable = 4'h0;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        for (int k = 0; k < 6; k++) begin
            rd(ra[k]);
            check("reset value", q, rv[k]);
        end
        check("enables after reset", {16'h0, pinOe}, 32'h0);
        $display("test reset values done");
        wr(8'h0C, 32'h0);
        rd(8'h0C);
        check("period floor", q, 32'h1);
        xfer(1'b0, 8'h0C, 32'hFFFF_FF07, 4'h1);
        rd(8'h0C);
        check("period byte lane", q, 32'h7);
        wr(8'h10, 32'hFFFF_FFFF);
        rd(8'h10);
        check("square ceiling", q, pfo_pkg::SQ_MAX_INC);
        $display("test limits done");
        wr(8'h04, 32'h4000_0000);
        wr(8'h08, 32'h8000);
        rd(pfo_pkg::PINS_ADDR);
        check("level on pin 15", q, 32'h8000_8000);
        wr(8'h04, 32'hAAAA_AAAA);
        rd(pfo_pkg::PINS_ADDR);
        check("pwm enables", q & 32'hFFFF_0000, 32'hFFFF_0000);
        for (int k = 0; k < 6; k++) begin
            wr(8'h00, 32'h0);
            wr(8'h0C, 32'(pp[k]));
            wr(8'h40, 32'(pd[k]));
            wr(8'h00, 32'h1);
            measure(pp[k] * 500);
            check("pwm high time", 32'(hi0), 32'((pd[k] < pp[k] ? pd[k] : pp[k]) * 500));
            check("pwm full duty pin", 32'(hi1), 32'(pp[k] * 500));
        end
        $display("test pwm done");
        wr(8'h00, 32'h0);
        wr(8'h0C, 32'h3E8);
        wr(8'h00, 32'h1);
        repeat (600) @(posedge clk);
        rd(pfo_pkg::COUNT_ADDR);
        check("tick count", q, 32'h2);
        wr(8'h00, 32'h3);
        rd(pfo_pkg::COUNT_ADDR);
        check("count after restart", q, 32'h0);
        rd(8'h00);
        check("restart self clear", q, 32'h1);
        $display("test count done");
        wr(8'h00, 32'h0);
        wr(8'h04, 32'hFFFF_FFFF);
        wr(8'h44, 32'h4000);
        wr(8'h40, 32'h8000);
        wr(8'h10, pfo_pkg::SQ_MAX_INC >> 2);
        wr(8'h00, 32'h1);
        measure(1000);
        check("square mark space", near(hi0, 500, 4), 32'h1);
        check("square own duty", near(hi1, 250, 4), 32'h1);
        check("square 1 MHz edges", near(ed0, 4, 1), 32'h1);
        wr(8'h00, 32'h0);
        wr(8'h10, pfo_pkg::SQ_MAX_INC);
        wr(8'h00, 32'h1);
        measure(1000);
        check("square 4 MHz edges", near(ed0, 16, 1), 32'h1);
        check("square 4 MHz duty", near(hi1, 250, 8), 32'h1);
        $display("test square done");
        summarize();
    end
    // Hang guard well past the longest expected run
    initial begin
        #400000;
        n_errors++;
        summarize();
    end
endmodule
